//--- design/dhirc_top.sv
// Bring-up sequencing, init commands and calibration with AXI regs
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`include "dhirc_defines.svh"
module dhirc_top (
  // Register clock and reset
  input logic aclk,
  input logic aresetn,
  // AXI4-Lite write address
  input logic [7:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  // AXI4-Lite read address
  input logic [7:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // DIMM link clock and read side
  input logic dclk,
  input logic rd_issue,
  input logic [7:0] dq_in,
  input logic dqs_in,
  // DIMM command side
  output dhirc_pkg::dhirc_dimm_cmd_t dimm_cmd,
  output logic dimm_clk_en,
  output logic dimm_cke,
  // Capture results
  output logic capture_window,
  output dhirc_pkg::dhirc_rd_t rd_out,
  // Core status
  output logic [4:0] strobe_delay_taps,
  output logic main_ready
);
  // ----------------------------------------------------------
  // State
  // ----------------------------------------------------------
  // All register-domain state in one record
  typedef struct packed {
    dhirc_pkg::dhirc_pwr_t pwr;
    logic [5:0] step_cnt;
    logic [5:0] cal_cnt;
    logic cal;
    logic cal_done;
    logic busy;
    logic req_tgl;
    logic ack_s1, ack_s2, ack_s3;
    logic asst_s1, asst_s2, asst_s3;
    logic [7:0] assist;
    logic link_run;
    // Bus slave bookkeeping
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // Software registers
    logic [1:0] ctrl;
    logic [19:0] init_addr;
    logic [2:0] cas;
    logic [2:0] dpl;
    logic tsize;
    logic [15:0] geom;
    logic [4:0] sdel;
    logic [2:0] last_cmd;
    dhirc_pkg::dhirc_dimm_cmd_t cmd_word;
  } dhirc_st_t;

  dhirc_st_t r_reg, r_next;

  // Link-side answers, and the read timing handed to the link
  logic ack_tgl;
  logic [7:0] assist_val;
  logic assist_tgl;
  dhirc_pkg::dhirc_cfg_t cfg;

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  // Merge write data into an old word under byte strobes
  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Build the DIMM command word for an init code
  function automatic dhirc_pkg::dhirc_dimm_cmd_t cmd_word_of(
    input logic [2:0] code,
    input logic [19:0] where
  );
    dhirc_pkg::dhirc_dimm_cmd_t c;
    c.cs_n = 8'hff;
    c.ras_n = 1'b1;
    c.cas_n = 1'b1;
    c.we_n = 1'b1;
    c.addr = where[14:0];
    c.ba = where[16:15];
    if (code != `DHIRC_CMD_NOP) begin
      // Select the one rank that the address register names
      c.cs_n[where[19:17]] = 1'b0;
    end
    if (code == `DHIRC_CMD_PRE_ALL) begin
      c.ras_n = 1'b0;
      c.we_n = 1'b0;
      c.addr[`DHIRC_PA_BIT] = 1'b1;
    end else if (code == `DHIRC_CMD_MRS) begin
      // Opcode rides on address and bank lines
      c.ras_n = 1'b0;
      c.cas_n = 1'b0;
      c.we_n = 1'b0;
    end else if (code == `DHIRC_CMD_REFRESH) begin
      c.ras_n = 1'b0;
      c.cas_n = 1'b0;
    end
    return c;
  endfunction

  // ----------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------
  // One write and one read at a time; ready drops until answered
  assign s_axi_awready = !r_reg.aw_got && !r_reg.bvalid;
  assign s_axi_wready = !r_reg.w_got && !r_reg.bvalid;
  assign s_axi_arready = !r_reg.rvalid;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rdata = r_reg.rdata;
  assign s_axi_rresp = r_reg.rresp;

  // ----------------------------------------------------------
  // Next state
  // ----------------------------------------------------------
  // Bus slave, power sequence, init commands and calibration
  always_comb begin
    logic [31:0] wv;
    logic [31:0] rv;
    logic hit;
    wv = 32'h0000_0000;
    rv = 32'h0000_0000;
    hit = 1'b1;
    r_next = r_reg;

    // Crossing flops for link acknowledges and assist results
    r_next.ack_s1 = ack_tgl;
    r_next.ack_s2 = r_reg.ack_s1;
    r_next.ack_s3 = r_reg.ack_s2;
    r_next.asst_s1 = assist_tgl;
    r_next.asst_s2 = r_reg.asst_s1;
    r_next.asst_s3 = r_reg.asst_s2;

    // Assist value is stable once its toggle has crossed
    if (r_reg.asst_s2 != r_reg.asst_s3) begin
      r_next.assist = assist_val;
    end

    // Init command done once the link has played it out
    if (r_reg.busy && r_reg.ack_s2 != r_reg.ack_s3) begin
      r_next.busy = 1'b0;
    end

    // Calibration runs its fixed time, then loads the delay
    if (r_reg.cal) begin
      r_next.cal_cnt = r_reg.cal_cnt + 6'h01;
      if (r_reg.cal_cnt == 6'(`DHIRC_CAL_CYC - 1)) begin
        r_next.cal = 1'b0;
        r_next.cal_done = 1'b1;
        r_next.sdel = 5'(`DHIRC_STROBE_TAPS);
      end
    end

    // Power sequence; software steps it over the AXI registers
    case (r_reg.pwr)
      dhirc_pkg::PWR_DOWN: begin
        // Only the register port lives here
        if (r_reg.ctrl[`DHIRC_CTRL_UP]) begin
          r_next.pwr = dhirc_pkg::PWR_STEP;
          r_next.step_cnt = 6'h00;
        end
      end
      dhirc_pkg::PWR_STEP: begin
        // Core needs a fixed settling time before sync
        r_next.step_cnt = r_reg.step_cnt + 6'h01;
        if (!r_reg.ctrl[`DHIRC_CTRL_UP]) begin
          r_next.pwr = dhirc_pkg::PWR_DOWN;
        end else if (r_reg.step_cnt == 6'(`DHIRC_STEP_CYC - 1)) begin
          r_next.pwr = dhirc_pkg::PWR_SYNC;
        end
      end
      dhirc_pkg::PWR_SYNC: begin
        // Wait for the channel synchronisation step
        if (!r_reg.ctrl[`DHIRC_CTRL_UP]) begin
          r_next.pwr = dhirc_pkg::PWR_DOWN;
        end else if (r_reg.ctrl[`DHIRC_CTRL_SYNC]) begin
          r_next.pwr = dhirc_pkg::PWR_UP;
        end
      end
      default: begin
        // Clearing the power bit returns to powered-down idle
        if (!r_reg.ctrl[`DHIRC_CTRL_UP]) begin
          r_next.pwr = dhirc_pkg::PWR_DOWN;
        end
      end
    endcase
    // Leaving power-up drops work in flight and holds the core
    if (r_next.pwr != dhirc_pkg::PWR_UP) begin
      r_next.busy = 1'b0;
      r_next.cal = 1'b0;
    end
    r_next.link_run = (r_next.pwr == dhirc_pkg::PWR_UP);

    // Write channels may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      r_next.aw_got = 1'b1;
      r_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      r_next.w_got = 1'b1;
      r_next.wdata = s_axi_wdata;
      r_next.wstrb = s_axi_wstrb;
    end

    // Both halves held: perform the write and answer
    if (r_reg.aw_got && r_reg.w_got) begin
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = `DHIRC_RESP_OKAY;
      if (r_reg.awaddr == `DHIRC_OFF_CTRL) begin
        wv = merge_bytes({30'h0, r_reg.ctrl}, r_reg.wdata,
          r_reg.wstrb);
        r_next.ctrl = wv[1:0];
      end else if (r_reg.awaddr == `DHIRC_OFF_INIT) begin
        wv = merge_bytes(32'h0000_0000, r_reg.wdata, r_reg.wstrb);
        if (r_reg.busy || r_reg.cal) begin
          // Refused while a command or calibration runs
          r_next.bresp = `DHIRC_RESP_SLVERR;
        end else if (r_reg.pwr != dhirc_pkg::PWR_UP) begin
          // No DIMM traffic before core power-up
          r_next.bresp = `DHIRC_RESP_SLVERR;
        end else if (wv[7:0] == `DHIRC_CAL_CODE) begin
          r_next.cal = 1'b1;
          r_next.cal_cnt = 6'h00;
          r_next.cal_done = 1'b0;
        end else begin
          r_next.last_cmd = wv[2:0];
          r_next.cmd_word = cmd_word_of(wv[2:0],
            r_reg.init_addr);
          r_next.req_tgl = ~r_reg.req_tgl;
          r_next.busy = 1'b1;
        end
      end else if (r_reg.awaddr == `DHIRC_OFF_INIT_ADDR) begin
        wv = merge_bytes({12'h000, r_reg.init_addr}, r_reg.wdata,
          r_reg.wstrb);
        r_next.init_addr = wv[19:0];
      end else if (r_reg.awaddr == `DHIRC_OFF_BRANCH_TIM) begin
        wv = merge_bytes({25'h0, r_reg.dpl, 1'b0, r_reg.cas},
          r_reg.wdata, r_reg.wstrb);
        r_next.cas = wv[2:0];
        r_next.dpl = wv[6:4];
      end else if (r_reg.awaddr == `DHIRC_OFF_MAIN_TIM) begin
        wv = merge_bytes({31'h0, r_reg.tsize}, r_reg.wdata,
          r_reg.wstrb);
        r_next.tsize = wv[0];
      end else if (r_reg.awaddr == `DHIRC_OFF_GEOM) begin
        wv = merge_bytes({16'h0000, r_reg.geom}, r_reg.wdata,
          r_reg.wstrb);
        r_next.geom = wv[15:0];
      end else if (r_reg.awaddr == `DHIRC_OFF_STROBE_TIM) begin
        wv = merge_bytes({27'h0, r_reg.sdel}, r_reg.wdata,
          r_reg.wstrb);
        r_next.sdel = wv[4:0];
      end else if (r_reg.awaddr == `DHIRC_OFF_STATUS ||
        r_reg.awaddr == `DHIRC_OFF_ASSIST) begin
        // Read-only words: write has no effect
        r_next.bresp = `DHIRC_RESP_OKAY;
      end else begin
        r_next.bresp = `DHIRC_RESP_SLVERR;
      end
    end
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end

    // Read: data the cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      if (s_axi_araddr == `DHIRC_OFF_CTRL) begin
        rv = {30'h0, r_reg.ctrl};
      end else if (s_axi_araddr == `DHIRC_OFF_STATUS) begin
        rv = {29'h0, r_reg.cal_done, r_reg.pwr};
      end else if (s_axi_araddr == `DHIRC_OFF_INIT) begin
        // In-progress bit covers both commands and calibration
        rv = {24'h0, (r_reg.busy || r_reg.cal), 4'h0,
          r_reg.last_cmd};
      end else if (s_axi_araddr == `DHIRC_OFF_INIT_ADDR) begin
        rv = {12'h000, r_reg.init_addr};
      end else if (s_axi_araddr == `DHIRC_OFF_BRANCH_TIM) begin
        rv = {25'h0, r_reg.dpl, 1'b0, r_reg.cas};
      end else if (s_axi_araddr == `DHIRC_OFF_MAIN_TIM) begin
        rv = {31'h0, r_reg.tsize};
      end else if (s_axi_araddr == `DHIRC_OFF_GEOM) begin
        rv = {16'h0000, r_reg.geom};
      end else if (s_axi_araddr == `DHIRC_OFF_STROBE_TIM) begin
        rv = {27'h0, r_reg.sdel};
      end else if (s_axi_araddr == `DHIRC_OFF_ASSIST) begin
        rv = {24'h0, r_reg.assist};
      end else begin
        hit = 1'b0;
      end
      r_next.rvalid = 1'b1;
      r_next.rdata = rv;
      r_next.rresp = hit ? `DHIRC_RESP_OKAY : `DHIRC_RESP_SLVERR;
    end else if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  // Reset lands in powered-down idle with everything cleared
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------
  // Timing set by software before any read; crossed as levels
  assign cfg.cas = r_reg.cas;
  assign cfg.dpl = r_reg.dpl;
  assign cfg.long_burst = r_reg.tsize;

  // DIMM side logic on its own clock
  dhirc_link u_link (
    .dclk(dclk),
    .run_in(r_reg.link_run),
    .req_tgl_in(r_reg.req_tgl),
    .cmd_in(r_reg.cmd_word),
    .cfg_in(cfg),
    .rd_issue(rd_issue),
    .dq_in(dq_in),
    .dqs_in(dqs_in),
    .dimm_cmd(dimm_cmd),
    .dimm_clk_en(dimm_clk_en),
    .dimm_cke(dimm_cke),
    .capture_window(capture_window),
    .rd_out(rd_out),
    .ack_tgl(ack_tgl),
    .assist_val(assist_val),
    .assist_tgl(assist_tgl)
  );

  // ----------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------
  // Main channel is usable only once fully synchronised
  assign main_ready = r_reg.link_run;
  // Drives the read strobe delay line
  assign strobe_delay_taps = r_reg.sdel;
endmodule

//--- design/dhirc_defines.svh
// Constants for the memory hub bring-up and read capture block
`ifndef DHIRC_DEFINES_SVH
`define DHIRC_DEFINES_SVH
// ----------------------------------------------------------
// Register offsets
// ----------------------------------------------------------
`define DHIRC_OFF_CTRL 8'h00
`define DHIRC_OFF_STATUS 8'h04
`define DHIRC_OFF_INIT 8'h08
`define DHIRC_OFF_INIT_ADDR 8'h0c
`define DHIRC_OFF_BRANCH_TIM 8'h10
`define DHIRC_OFF_MAIN_TIM 8'h14
`define DHIRC_OFF_GEOM 8'h18
`define DHIRC_OFF_STROBE_TIM 8'h1c
`define DHIRC_OFF_ASSIST 8'h20
// ----------------------------------------------------------
// Fields, codes and responses
// ----------------------------------------------------------
`define DHIRC_CTRL_UP 0
`define DHIRC_CTRL_SYNC 1
`define DHIRC_INIT_BUSY 7
`define DHIRC_CAL_CODE 8'h81
`define DHIRC_CMD_NOP 3'h0
`define DHIRC_CMD_PRE_ALL 3'h1
`define DHIRC_CMD_MRS 3'h2
`define DHIRC_CMD_REFRESH 3'h3
`define DHIRC_PA_BIT 10
`define DHIRC_REG_DELAY 4'h1
`define DHIRC_SHORT_BEATS 3'h2
`define DHIRC_LONG_BEATS 3'h4
`define DHIRC_RESP_OKAY 2'b00
`define DHIRC_RESP_SLVERR 2'b10
// ----------------------------------------------------------
// Times and derived counts
// ----------------------------------------------------------
`define DHIRC_CLK_NS 40
`define DHIRC_CORE_STEP_NS 1000
`define DHIRC_CAL_NS 2000
`define DHIRC_STEP_CYC ((`DHIRC_CORE_STEP_NS+`DHIRC_CLK_NS-1)/`DHIRC_CLK_NS)
`define DHIRC_CAL_CYC ((`DHIRC_CAL_NS+`DHIRC_CLK_NS-1)/`DHIRC_CLK_NS)
`define DHIRC_STROBE_PS 2200
`define DHIRC_TAP_PS 100
`define DHIRC_STROBE_TAPS (`DHIRC_STROBE_PS/`DHIRC_TAP_PS)
`endif

//--- design/dhirc_pkg.sv
// Types shared by the bring-up and read capture block
package dhirc_pkg;
  // Power-up sequence state
  typedef enum logic [1:0] {
    PWR_DOWN, PWR_STEP, PWR_SYNC, PWR_UP
  } dhirc_pwr_t;
  // One command word on a branch channel
  typedef struct packed {
    logic [7:0] cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [14:0] addr;
    logic [1:0] ba;
  } dhirc_dimm_cmd_t;
  // Read timing handed to the link domain
  typedef struct packed {
    logic [2:0] cas;
    logic [2:0] dpl;
    logic long_burst;
  } dhirc_cfg_t;
  // One captured read beat
  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } dhirc_rd_t;
endpackage

//--- design/dhirc_link.sv
// Link-clock logic: DIMM commands, clock enables, capture window
`timescale 1ns/10ps
`include "dhirc_defines.svh"
module dhirc_link (
  // Link clock
  input logic dclk,
  // From the register domain
  input logic run_in,
  input logic req_tgl_in,
  input dhirc_pkg::dhirc_dimm_cmd_t cmd_in,
  input dhirc_pkg::dhirc_cfg_t cfg_in,
  // Read side pins and read strobe
  input logic rd_issue,
  input logic [7:0] dq_in,
  input logic dqs_in,
  // To the DIMMs, and the capture window and read beat
  output dhirc_pkg::dhirc_dimm_cmd_t dimm_cmd,
  output logic dimm_clk_en,
  output logic dimm_cke,
  output logic capture_window,
  output dhirc_pkg::dhirc_rd_t rd_out,
  // Back to the register domain
  output logic ack_tgl,
  output logic [7:0] assist_val,
  output logic assist_tgl
);
  // Idle command: no chip selected
  localparam dhirc_pkg::dhirc_dimm_cmd_t NOP_CMD = '{
    cs_n: 8'hff, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
    addr: 15'h0000, ba: 2'h0};

  // All link-side state
  typedef struct packed {
    logic run_s1, run_s2;
    logic req_s1, req_s2, req_s3;
    dhirc_pkg::dhirc_cfg_t cfg_s1, cfg_s2;
    logic [7:0] dq_s1, dq_s2;
    logic dqs_s1, dqs_s2;
    dhirc_pkg::dhirc_dimm_cmd_t cmd;
    logic clk_en, cke;
    logic [3:0] cnt;
    logic win;
    logic [2:0] left;
    dhirc_pkg::dhirc_rd_t rd;
    logic [7:0] a_cnt;
    logic a_busy;
    logic [7:0] a_val;
    logic a_tgl, ack;
  } dhirc_lst_t;

  dhirc_lst_t r_reg, r_next;

  // Next-state logic
  always_comb begin
    r_next = r_reg;
    // Two-flop synchronisers; quasi-static config is set before use
    r_next.run_s1 = run_in;
    r_next.run_s2 = r_reg.run_s1;
    r_next.req_s1 = req_tgl_in;
    r_next.req_s2 = r_reg.req_s1;
    r_next.req_s3 = r_reg.req_s2;
    r_next.cfg_s1 = cfg_in;
    r_next.cfg_s2 = r_reg.cfg_s1;
    r_next.dq_s1 = dq_in;
    r_next.dq_s2 = r_reg.dq_s1;
    r_next.dqs_s1 = dqs_in;
    r_next.dqs_s2 = r_reg.dqs_s1;
    r_next.cmd = NOP_CMD;
    r_next.rd.valid = 1'b0;
    if (!r_reg.run_s2) begin
      // Held in reset until the core is powered up
      r_next.clk_en = 1'b0;
      r_next.cke = 1'b0;
      r_next.cnt = 4'h0;
      r_next.win = 1'b0;
      r_next.left = 3'h0;
      r_next.rd = '0;
      r_next.a_busy = 1'b0;
      r_next.a_cnt = 8'h00;
      r_next.a_val = 8'h00;
      r_next.a_tgl = 1'b0;
      // Track the request so no stale toggle fires at release
      r_next.ack = r_reg.req_s2;
    end else begin
      // Powered up: clocks run, CKE high, NOP between commands
      r_next.clk_en = 1'b1;
      r_next.cke = 1'b1;
      if (r_reg.req_s2 != r_reg.req_s3) begin
        // One init command for one DIMM clock, acknowledged in the same cycle
        r_next.cmd = cmd_in;
        r_next.ack = r_reg.req_s2;
      end
      // Window opens CAS + registered delay + path latency later
      if (rd_issue) begin
        r_next.cnt = 4'(r_reg.cfg_s2.cas) + `DHIRC_REG_DELAY
          + 4'(r_reg.cfg_s2.dpl);
      end else if (r_reg.cnt != 4'h0) begin
        r_next.cnt = r_reg.cnt - 4'h1;
      end
      if (!rd_issue && r_reg.cnt == 4'h1) begin
        r_next.win = 1'b1;
        r_next.left = r_reg.cfg_s2.long_burst ? `DHIRC_LONG_BEATS
          : `DHIRC_SHORT_BEATS;
      end else if (r_reg.win) begin
        r_next.left = r_reg.left - 3'h1;
        if (r_reg.left == 3'h1) begin
          r_next.win = 1'b0;
        end
      end
      // Strobe events count only inside the window
      if (r_reg.win && r_reg.dqs_s2) begin
        r_next.rd.data = r_reg.dq_s2;
        r_next.rd.valid = 1'b1;
      end
      // Assist: clocks from read to first strobe seen
      if (rd_issue) begin
        r_next.a_busy = 1'b1;
        r_next.a_cnt = 8'h00;
      end else if (r_reg.a_busy) begin
        r_next.a_cnt = r_reg.a_cnt + 8'h01;
        if (r_reg.dqs_s2) begin
          r_next.a_val = r_reg.a_cnt;
          r_next.a_tgl = ~r_reg.a_tgl;
          r_next.a_busy = 1'b0;
        end else if (r_reg.a_cnt == 8'hff) begin
          r_next.a_busy = 1'b0;
        end
      end
    end
  end

  // State register; reset arrives through the run synchroniser
  always_ff @(posedge dclk) begin
    r_reg <= r_next;
  end

  assign dimm_cmd = r_reg.cmd;
  assign dimm_clk_en = r_reg.clk_en;
  assign dimm_cke = r_reg.cke;
  assign capture_window = r_reg.win;
  assign rd_out = r_reg.rd;
  assign ack_tgl = r_reg.ack;
  assign assist_val = r_reg.a_val;
  assign assist_tgl = r_reg.a_tgl;
endmodule

//--- sim/dhirc_top_asserts.sv
// Checker on the top ports of the bring-up and read capture block
`timescale 1ns/10ps
module dhirc_top_asserts (
  // Clocks and reset
  input logic aclk,
  input logic aresetn,
  input logic dclk,
  // Bus answers
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [31:0] s_axi_rdata,
  // Link outputs and core status
  input dhirc_pkg::dhirc_dimm_cmd_t dimm_cmd,
  input logic dimm_clk_en,
  input logic dimm_cke,
  input logic capture_window,
  input dhirc_pkg::dhirc_rd_t rd_out,
  input logic main_ready
);
  // Core must come out of reset powered down
  a_first_idle: assert property (
    @(posedge aclk) disable iff (!aresetn) $rose(aresetn) |-> !main_ready)
    else $error("core ready at reset release");
  // A pending write answer must hold still
  a_write_hold: assert property (
    @(posedge aclk) disable iff (!aresetn) s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  // A pending read answer must hold still
  a_read_hold: assert property (
    @(posedge aclk) disable iff (!aresetn) s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  // Clock enable and DIMM clocks rise and fall as one
  a_cke_pair: assert property (
    @(posedge dclk) disable iff (!aresetn) dimm_cke == dimm_clk_en)
    else $error("cke and clock enable differ");
  // No command may reach the DIMMs while they are parked
  a_nop_down: assert property (
    @(posedge dclk) disable iff (!aresetn) !dimm_cke |-> &dimm_cmd.cs_n)
    else $error("command while powered down");
  // Init commands are single-cycle, NOP follows
  a_cmd_single: assert property (
    @(posedge dclk) disable iff (!aresetn) !(&dimm_cmd.cs_n)
    |=> &dimm_cmd.cs_n) else $error("command longer than one cycle");
  // Window spans two to four beats, never more
  a_window_len: assert property (
    @(posedge dclk) disable iff (!aresetn) $rose(capture_window)
    |-> capture_window ##1 capture_window ##[1:3] !capture_window)
    else $error("capture window length wrong");
  // Floating-bus glitches outside the capture window must never yield a beat
  a_rx_window: assert property (
    @(posedge dclk) disable iff (!aresetn) rd_out.valid
    |-> $past(capture_window)) else $error("beat outside window");
  // Main scenarios reached
  c_beat: cover property (@(posedge dclk) rd_out.valid);
  c_cmd: cover property (@(posedge dclk) !(&dimm_cmd.cs_n));
  c_up: cover property (@(posedge aclk) $rose(main_ready));
endmodule
bind dhirc_top dhirc_top_asserts i_chk (.aclk(aclk), .aresetn(aresetn),
  .dclk(dclk), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .dimm_cmd(dimm_cmd), .dimm_clk_en(dimm_clk_en), .dimm_cke(dimm_cke),
  .capture_window(capture_window), .rd_out(rd_out),
  .main_ready(main_ready));

//--- sim/dhirc_dimm_model.sv
// DIMM read-side model: strobe burst after a read, floating lines else
`timescale 1ns/10ps
module dhirc_dimm_model (
  // Link clock and read issue
  input logic dclk,
  input logic rd_issue,
  // Burst start delay and burst data
  input logic [3:0] lat,
  input logic [7:0] data,
  // Data and strobe pins
  output logic [7:0] dq,
  output logic dqs
);
  int t = -1; // Cycles since the read, -1 when idle
  initial begin
    dq = 8'h00;
    dqs = 1'h0;
  end
  // Eight-beat burst; a late lat makes a slow DIMM
  always @(posedge dclk) begin
    t <= rd_issue ? 0 : (t >= 0 && t < 40) ? t + 1 : -1;
    if (t >= lat && t < lat + 8) begin
      dq <= data;
      dqs <= 1'h1;
    end else begin
      // Released lines glitch every cycle, never hold a level
      dq <= ~dq;
      dqs <= ~dqs;
    end
  end
endmodule

//--- sim/dhirc_top_tb_top.sv
// Self-checking bench for the bring-up and read capture block
`timescale 1ns/10ps
`include "dhirc_defines.svh"
module dhirc_top_tb_top;
  logic aclk, dclk, aresetn = 1'h0, rd_issue = 1'h0, cw_d;
  logic aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0;
  logic aw_r, w_r, b_v, ar_r, r_v, dqs, clk_en, cke, cw, up;
  logic [7:0] aw_a = 8'h0, ar_a = 8'h0, dq, dval = 8'h0, dlast;
  logic [31:0] w_d = 32'h0, r_data, d;
  logic [1:0] b_resp, r_resp, r;
  logic [3:0] lat = 4'h0;
  logic [4:0] taps;
  dhirc_pkg::dhirc_dimm_cmd_t cmd, seen;
  dhirc_pkg::dhirc_rd_t rdo;
  int errors = 0, samples_checked = 0, cnt = 0, open_at, vcnt;
  localparam logic [8:0] RCW = 9'h042; // ras,cas,we of codes 3..1
  dhirc_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
    .s_axi_rready(r_r), .dclk(dclk), .rd_issue(rd_issue), .dq_in(dq),
    .dqs_in(dqs), .dimm_cmd(cmd), .dimm_clk_en(clk_en), .dimm_cke(cke),
    .capture_window(cw), .rd_out(rdo), .strobe_delay_taps(taps),
    .main_ready(up));
  dhirc_dimm_model i_dimm (.dclk(dclk), .rd_issue(rd_issue), .lat(lat),
    .data(dval), .dq(dq), .dqs(dqs));
  // Register clock, and a link clock of unrelated phase
  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    dclk = 1'h0;
    #1.3;
    forever #3 dclk = ~dclk;
  end
  // Link-side monitor: window start, beats, last command seen
  always @(posedge dclk) begin
    cnt <= rd_issue ? 0 : cnt + 1;
    cw_d <= cw;
    if (cw && !cw_d) open_at <= cnt;
    if (rd_issue) vcnt <= 0;
    else if (rdo.valid) vcnt <= vcnt + 1;
    if (rdo.valid) dlast <= rdo.data;
    if (cmd.cs_n != 8'hff) seen <= cmd;
  end
  task chk(input logic [39:0] g, input logic [39:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task tally_and_finish;
    if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Write: address and data released separately as each is taken
  task wr(input logic [7:0] a, input logic [31:0] v);
    aw_a <= a;
    w_d <= v;
    aw_v <= 1'h1;
    w_v <= 1'h1;
    fork
      begin do @(posedge aclk); while (!aw_r); aw_v <= 1'h0; end
      begin do @(posedge aclk); while (!w_r); w_v <= 1'h0; end
    join
    while (!b_v) @(posedge aclk);
    b_r <= 1'h1;
    @(posedge aclk);
    r = b_resp;
    b_r <= 1'h0;
  endtask
  task rd(input logic [7:0] a);
    ar_a <= a;
    ar_v <= 1'h1;
    do @(posedge aclk); while (!ar_r);
    ar_v <= 1'h0;
    while (!r_v) @(posedge aclk);
    r_r <= 1'h1;
    @(posedge aclk);
    d = r_data;
    r = r_resp;
    r_r <= 1'h0;
  endtask
  // Bounded poll: the device may take many cycles to finish
  task poll(input logic [7:0] a, input logic [31:0] m, v);
    repeat (200) begin
      rd(a);
      if ((d & m) == v) break;
    end
    chk(d & m, v);
  endtask
  // One read: window must open at CAS+1+path and span the burst
  task burst(input logic [2:0] cas, pl, input logic lb, logic [7:0] v);
    wr(`DHIRC_OFF_BRANCH_TIM, {pl, 1'h0, cas});
    wr(`DHIRC_OFF_MAIN_TIM, {31'h0, lb});
    lat <= 4'(cas + pl + 1 - 4);
    dval <= v;
    repeat (4) @(posedge aclk);
    @(posedge dclk) rd_issue <= 1'h1;
    @(posedge dclk) rd_issue <= 1'h0;
    repeat (30) @(posedge dclk);
    chk(open_at, cas + pl + 1);
    chk(vcnt, lb ? 4 : 2);
    chk(dlast, v);
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(`DHIRC_OFF_STATUS);
    chk(d & 32'h3, 32'h0);
    chk({up, cke, clk_en}, 3'h0);
    wr(`DHIRC_OFF_INIT, 32'h2);
    chk(r, `DHIRC_RESP_SLVERR);
    rd(8'h40);
    chk({d, r}, {32'h0, `DHIRC_RESP_SLVERR});
    wr(`DHIRC_OFF_CTRL, 32'h1);
    poll(`DHIRC_OFF_STATUS, 32'h3, 32'h2);
    wr(`DHIRC_OFF_CTRL, 32'h3);
    poll(`DHIRC_OFF_STATUS, 32'h3, 32'h3);
    repeat (4) @(posedge aclk);
    chk({up, cke, clk_en, cmd.cs_n}, {3'h7, 8'hff});
    wr(`DHIRC_OFF_INIT_ADDR, 32'h40000);
    for (int c = 1; c < 4; c++) begin
      wr(`DHIRC_OFF_INIT, c);
      poll(`DHIRC_OFF_INIT, 32'h80, 32'h0);
      chk({seen.cs_n, seen.ras_n, seen.cas_n, seen.we_n, seen.addr},
        {8'hfb, RCW[3*c-3 +: 3], (c == 1) ? 15'h400 : 15'h0});
    end
    wr(`DHIRC_OFF_INIT, 32'h81);
    rd(`DHIRC_OFF_INIT);
    chk(d[7], 1'h1);
    wr(`DHIRC_OFF_INIT, 32'h1);
    chk(r, `DHIRC_RESP_SLVERR);
    poll(`DHIRC_OFF_INIT, 32'h80, 32'h0);
    rd(`DHIRC_OFF_STATUS);
    chk(d[2], 1'h1);
    chk(taps, 5'h16);
    wr(`DHIRC_OFF_GEOM, 32'h1234);
    rd(`DHIRC_OFF_GEOM);
    chk(d, 32'h1234);
    burst(3'h2, 3'h1, 1'h0, 8'h5a);
    burst(3'h3, 3'h2, 1'h1, 8'ha5);
    tally_and_finish;
  end
  // A hang counts as a failure
  initial begin
    #300us;
    errors++;
    tally_and_finish;
  end
endmodule
